// ===== common/bitmr_pkg.sv
// constants for the basic interval timer: register map, control field layout, reset values, prescale taps
// assumes a single 40 MHz clock domain with the oscillator clock taken as the bus clock
package bitmr_pkg;
   localparam logic [7:0] BITMR_ADDR_COUNT = 8'hec;
   localparam logic [7:0] BITMR_ADDR_STATUS = 8'hf0;
   localparam logic [7:0] BITMR_ADDR_STOP = 8'hf4;
   localparam logic [7:0] BITMR_CTRL_RESET = 8'h17;
   localparam int BITMR_WAKE_BIT = 6;
   localparam int BITMR_RCWD_BIT = 5;
   localparam int BITMR_WDSEL_BIT = 4;
   localparam int BITMR_CLR_BIT = 3;
   localparam int BITMR_PS_LSB = 0;
   localparam int BITMR_PS_W = 3;
   localparam int BITMR_PRE_W = 11;
   localparam int BITMR_TAP_BASE = 2;
   localparam int BITMR_WAKE_TAP = 10;
   localparam int BITMR_STAT_FLAG_BIT = 0;
   localparam int BITMR_STAT_WAKE_BIT = 1;
   localparam int BITMR_STAT_RCWD_BIT = 2;
   localparam logic [1:0] BITMR_RESP_OKAY = 2'b00;
   localparam logic [1:0] BITMR_RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      BITMR_RUN = 2'b00,
      BITMR_WAKE = 2'b01,
      BITMR_RCWD = 2'b10
   } bitmr_mode_e;
endpackage : bitmr_pkg

// ===== hw/bitmr_prescaler.sv
// free-running oscillator divider with selectable count pulse and a fixed wake-up tap
// assumes aclk is the oscillator clock; nothing but reset ever clears it
`timescale 1ns/1ps
module bitmr_prescaler
   import bitmr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [BITMR_PS_W-1:0] sel,
   output logic count_pulse,
   output logic wake_pulse
);
   logic [BITMR_PRE_W-1:0] div_r;
   logic [BITMR_PRE_W-1:0] div_nxt;
   logic [7:0] tap_hit;

   assign div_nxt = div_r + 11'h001;

   // never cleared by the counter clear or a select change, other taps stay steady
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   // a tap fires when all its lower divider bits roll over together
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_tap
         assign tap_hit[g] = &div_r[g+BITMR_TAP_BASE:0];
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_pulse <= 1'b0;
         wake_pulse <= 1'b0;
      end else begin
         count_pulse <= tap_hit[sel];
         wake_pulse <= &div_r[BITMR_WAKE_TAP:0];
      end
   end
endmodule : bitmr_prescaler

// ===== hw/bitmr_timer.sv
// basic interval timer top: 8-bit count held in wake mode, shared read/write address, AXI4-Lite slave
// assumes software writes the control register with whole bytes; stop is a one-cycle input pulse
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bitmr_timer
   import bitmr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop_exec,
   input wire logic wake_event,
   output logic interval_irq_flag,
   output logic wake_tick,
   output logic watchdog_mode,
   output logic wake_mode,
   output logic rc_watchdog_mode
);
   logic [7:0] interval_count_r;
   logic [7:0] interval_clock_control_r;
   logic irq_flag_r;
   bitmr_mode_e mode_r;
   logic aw_held_r;
   logic [7:0] aw_addr_r;
   logic w_held_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic count_pulse;
   logic wake_pulse;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_ok;
   logic flag_clear;
   logic wrap;
   logic [7:0] count_nxt;
   logic [7:0] ctrl_nxt;

   bitmr_prescaler u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(interval_clock_control_r[BITMR_PS_LSB +: BITMR_PS_W]),
      .count_pulse(count_pulse),
      .wake_pulse(wake_pulse)
   );

   // write channel: address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   // only the low byte lane carries control; a write missing that lane is refused
   assign wr_ok = w_strb_r[0];
   assign wr_ctrl = wr_fire && wr_ok && (aw_addr_r[7:2] == BITMR_ADDR_COUNT[7:2]);
   assign wr_stat = wr_fire && wr_ok && (aw_addr_r[7:2] == BITMR_ADDR_STATUS[7:2]);
   assign flag_clear = wr_stat && w_data_r[BITMR_STAT_FLAG_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= BITMR_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_ok && ((aw_addr_r[7:2] == BITMR_ADDR_COUNT[7:2]) ||
            (aw_addr_r[7:2] == BITMR_ADDR_STATUS[7:2]))) ? BITMR_RESP_OKAY : BITMR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register; no read path exists, so partial updates cannot be merged
   always_comb begin
      ctrl_nxt = interval_clock_control_r;
      if (wr_ctrl) begin
         ctrl_nxt = w_data_r[7:0] & 8'h7f;
      end else begin
         ctrl_nxt[BITMR_CLR_BIT] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_clock_control_r <= BITMR_CTRL_RESET;
      end else begin
         interval_clock_control_r <= ctrl_nxt;
      end
   end

   // counter: nothing but the clear bit and wake mode ever holds it back
   assign wrap = count_pulse && (interval_count_r == 8'hff);

   always_comb begin
      count_nxt = interval_count_r;
      if (interval_clock_control_r[BITMR_CLR_BIT]) begin
         count_nxt = 8'h00;
      end else if (count_pulse && mode_r != BITMR_WAKE) begin
         count_nxt = interval_count_r + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_count_r <= 8'h00;
      end else begin
         interval_count_r <= count_nxt;
      end
   end

   // a wrap in the same cycle as a software clear keeps the flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_flag_r <= 1'b0;
      end else if (wrap && mode_r != BITMR_WAKE) begin
         irq_flag_r <= 1'b1;
      end else if (flag_clear) begin
         irq_flag_r <= 1'b0;
      end
   end

   // low-power mode entry on stop; wake enable wins if both enables are set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= BITMR_RUN;
      end else begin
         case (mode_r)
            BITMR_RUN: begin
               if (stop_exec && interval_clock_control_r[BITMR_WAKE_BIT]) begin
                  mode_r <= BITMR_WAKE;
               end else if (stop_exec && interval_clock_control_r[BITMR_RCWD_BIT]) begin
                  mode_r <= BITMR_RCWD;
               end
            end
            BITMR_WAKE: begin
               if (wake_event) begin
                  mode_r <= BITMR_RUN;
               end
            end
            BITMR_RCWD: begin
               if (wake_event) begin
                  mode_r <= BITMR_RUN;
               end
            end
            default: begin
               mode_r <= BITMR_RUN;
            end
         endcase
      end
   end

   // outputs are registered copies, one cycle behind the internal state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_irq_flag <= 1'b0;
      end else begin
         interval_irq_flag <= irq_flag_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_tick <= 1'b0;
      end else begin
         wake_tick <= wake_pulse;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_mode <= 1'b1;
      end else begin
         watchdog_mode <= interval_clock_control_r[BITMR_WDSEL_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_mode <= 1'b0;
      end else begin
         wake_mode <= (mode_r == BITMR_WAKE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_watchdog_mode <= 1'b0;
      end else begin
         rc_watchdog_mode <= (mode_r == BITMR_RCWD);
      end
   end

   // read channel: the shared address returns the count, not the control byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= BITMR_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= BITMR_RESP_OKAY;
            if (s_axi_araddr[7:2] == BITMR_ADDR_COUNT[7:2]) begin
               s_axi_rdata <= {24'h000000, interval_count_r};
            end else if (s_axi_araddr[7:2] == BITMR_ADDR_STATUS[7:2]) begin
               s_axi_rdata <= {29'h0, mode_r == BITMR_RCWD, mode_r == BITMR_WAKE, irq_flag_r};
            end else begin
               s_axi_rdata <= '0;
               s_axi_rresp <= BITMR_RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : bitmr_timer

// ===== bench/bitmr_timer_sva.sv
// checker for the interval timer top ports
// assumes the bench spaces control writes and stop pulses a few cycles apart
`timescale 1ns/1ps
module bitmr_timer_chk
   import bitmr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic stop_exec,
   input wire logic wake_event,
   input wire logic interval_irq_flag,
   input wire logic wake_tick,
   input wire logic watchdog_mode,
   input wire logic wake_mode,
   input wire logic rc_watchdog_mode
);
   logic [7:0] aw_r, wd_r, ctrl_r;
   logic [11:0] gap_r;
   logic seen_r;
   // shadow of the control byte, needed since its address reads back the count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r <= 8'h00;
         wd_r <= 8'h00;
         ctrl_r <= BITMR_CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
         if ($rose(s_axi_bvalid) && s_axi_bresp == BITMR_RESP_OKAY && aw_r == BITMR_ADDR_COUNT) ctrl_r <= wd_r;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= 12'h000;
         seen_r <= 1'b0;
      end else begin
         gap_r <= wake_tick ? 12'h000 : gap_r + 12'h001;
         seen_r <= seen_r | wake_tick;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ctrl_taken;
      $rose(s_axi_bvalid) && s_axi_bresp == BITMR_RESP_OKAY && aw_r == BITMR_ADDR_COUNT;
   endsequence
   sequence stop_idle;
      stop_exec && !wake_mode && !rc_watchdog_mode && !wake_event;
   endsequence
   reset_values_a: assert property ($rose(aresetn) |-> watchdog_mode && !wake_mode && !rc_watchdog_mode && !interval_irq_flag)
      else $error("outputs not at reset values");
   wdsel_follow_a: assert property (ctrl_taken |=> watchdog_mode == wd_r[4])
      else $error("watchdog select does not follow write");
   wake_entry_a: assert property (stop_idle ##0 ctrl_r[6] |-> ##[1:2] wake_mode)
      else $error("wake mode not entered");
   rc_entry_a: assert property (stop_idle ##0 ctrl_r[6:5] == 2'b01 |-> ##[1:2] rc_watchdog_mode)
      else $error("rc watchdog mode not entered");
   tick_pulse_a: assert property (wake_tick |=> !wake_tick)
      else $error("wake tick longer than one cycle");
   tick_period_a: assert property (wake_tick && seen_r |-> gap_r == 12'h7ff)
      else $error("wake tick period wrong");
   flag_sticky_a: assert property ($fell(interval_irq_flag) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("flag dropped without a write");
   wake_exit_a: assert property (wake_mode && wake_event |-> ##[1:2] !wake_mode)
      else $error("wake mode not left");
endmodule : bitmr_timer_chk

bind bitmr_timer bitmr_timer_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .stop_exec(stop_exec), .wake_event(wake_event), .interval_irq_flag(interval_irq_flag), .wake_tick(wake_tick),
   .watchdog_mode(watchdog_mode), .wake_mode(wake_mode), .rc_watchdog_mode(rc_watchdog_mode));

// ===== bench/testbench.sv
// self-checking bench for the interval timer over its AXI4-Lite port
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module testbench
   import bitmr_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, stop_exec = 1'b0, wake_event = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic interval_irq_flag, wake_tick, watchdog_mode, wake_mode, rc_watchdog_mode;
   int fails = 0, compares = 0, cyc = 0;
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   bitmr_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .stop_exec(stop_exec), .wake_event(wake_event), .interval_irq_flag(interval_irq_flag), .wake_tick(wake_tick),
      .watchdog_mode(watchdog_mode), .wake_mode(wake_mode), .rc_watchdog_mode(rc_watchdog_mode));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
      compares++;
      if (seen !== expd) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, expd, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic [3:0] strb, output logic [1:0] resp);
      s_axi_awaddr <= addr;
      s_axi_wdata <= {24'h000000, data};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // both reads start a whole number of periods apart, so the prescaler phase cancels out
   task automatic rate(input int period);
      logic [31:0] c0, c1;
      logic [1:0] r;
      int t0;
      t0 = cyc;
      rd(BITMR_ADDR_COUNT, c0, r);
      while (cyc < t0 + period * 4) @(posedge aclk);
      rd(BITMR_ADDR_COUNT, c1, r);
      check("count rate", {24'h000000, c1[7:0] - c0[7:0]}, 32'h4);
   endtask : rate
   task automatic strobe(input bit wake);
      if (wake) wake_event <= 1'b1;
      else stop_exec <= 1'b1;
      @(posedge aclk);
      wake_event <= 1'b0;
      stop_exec <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : strobe
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (40000) @(posedge aclk);
      fails++;
      summarize();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      check("reset outputs", {28'h0, watchdog_mode, wake_mode, rc_watchdog_mode, interval_irq_flag}, 32'h8);
      // let arready come up so both reads of the rate test see the same latency
      repeat (2) @(posedge aclk);
      rate(1024);
      for (int s = 0; s < 8; s++) begin
         wr(BITMR_ADDR_COUNT, {5'h02, 3'(s)}, 4'h1, r);
         rate(8 << s);
      end
      $display("test rate done");
      wr(BITMR_ADDR_COUNT, 8'h18, 4'h1, r);
      rd(BITMR_ADDR_COUNT, d, r);
      check("cleared count", 32'(d[7:0] <= 8'h01), 32'h1);
      repeat (160) @(posedge aclk);
      wr(BITMR_ADDR_COUNT, 8'h10, 4'h1, r);
      check("ctrl resp", {30'h0, r}, {30'h0, BITMR_RESP_OKAY});
      rd(BITMR_ADDR_COUNT, d, r);
      check("resumed count", 32'(d[7:0] >= 8'h13), 32'h1);
      $display("test clear done");
      wr(BITMR_ADDR_STATUS, 8'h01, 4'h1, r);
      wr(BITMR_ADDR_COUNT, 8'h18, 4'h1, r);
      repeat (1900) @(posedge aclk);
      check("flag early", {31'h0, interval_irq_flag}, 32'h0);
      repeat (200) @(posedge aclk);
      check("flag set", {31'h0, interval_irq_flag}, 32'h1);
      rd(BITMR_ADDR_STATUS, d, r);
      check("status flag", {31'h0, d[0]}, 32'h1);
      wr(BITMR_ADDR_STATUS, 8'h01, 4'h1, r);
      repeat (3) @(posedge aclk);
      check("flag cleared", {31'h0, interval_irq_flag}, 32'h0);
      $display("test overflow done");
      wr(8'h20, 8'h00, 4'h1, r);
      check("unmapped write", {30'h0, r}, {30'h0, BITMR_RESP_SLVERR});
      wr(BITMR_ADDR_COUNT, 8'h00, 4'h0, r);
      repeat (3) @(posedge aclk);
      check("strobe refused", {29'h0, r, watchdog_mode}, {29'h0, BITMR_RESP_SLVERR, 1'b1});
      rd(8'h20, d, r);
      check("unmapped read", d, 32'h0);
      $display("test refusal done");
      wr(BITMR_ADDR_COUNT, 8'h50, 4'h1, r);
      strobe(1'b0);
      check("wake entry", {30'h0, wake_mode, rc_watchdog_mode}, 32'h2);
      strobe(1'b1);
      wr(BITMR_ADDR_COUNT, 8'h20, 4'h1, r);
      strobe(1'b0);
      check("rc entry", {29'h0, wake_mode, rc_watchdog_mode, watchdog_mode}, 32'h2);
      strobe(1'b1);
      wr(BITMR_ADDR_COUNT, 8'h10, 4'h1, r);
      strobe(1'b0);
      check("plain stop", {29'h0, wake_mode, rc_watchdog_mode, watchdog_mode}, 32'h1);
      $display("test modes done");
      summarize();
   end
endmodule : testbench
